// File: src/cmm_pkg.sv
// constants and types for the capture/compare module mode control
// assumes a single clock domain and an 8-bit register port
// Functional notes
// - match enabled: counter equal to compare value sets the capture/compare flag
// - toggle enabled: each counter/compare match inverts the module output pin
// - toggle and pulse mode both set select frequency output mode
// - pulse mode enabled drives a pulse-width modulated waveform on the output pin
// - wide select 0 uses 8 to 15-bit modulator, 1 uses 16-bit modulator
// - flag interrupt enabled: a set capture/compare flag raises the interrupt request
// - watchdog enabled: module 2 mode writes ignored, module acts as watchdog
`default_nettype none
package cmm_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 16;
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_CMP_LO = 3'h1;
  localparam logic [2:0] ADDR_CMP_HI = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_CTRL = 3'h4;
  // mode register fields
  localparam int unsigned BIT_WIDE = 7;
  localparam int unsigned BIT_MATCH = 3;
  localparam int unsigned BIT_TOGGLE = 2;
  localparam int unsigned BIT_PULSE = 1;
  localparam int unsigned BIT_IRQ_EN = 0;
  // status register fields
  localparam int unsigned BIT_FLAG = 0;
  localparam int unsigned BIT_PIN = 1;
  localparam int unsigned BIT_IRQ = 2;
  // control register fields
  localparam int unsigned BIT_WDT_EN = 0;
  localparam int unsigned EXTRA_LSB = 1;
  localparam int unsigned EXTRA_MSB = 3;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int unsigned MODULE_INDEX = 2;
  localparam int unsigned WDT_MODULE = 2;
  localparam logic [3:0] PWM_SPAN = 4'h8;
  localparam logic [15:0] MASK_ALL = 16'hFFFF;

  typedef enum logic [2:0] {
    CMM_OFF = 3'h0,
    CMM_TOGGLE = 3'h1,
    CMM_PWM_NARROW = 3'h3,
    CMM_PWM_WIDE = 3'h2,
    CMM_FREQ = 3'h6
  } cmm_mode_e;

  function automatic cmm_mode_e cmm_decode(input logic [7:0] mode);
    cmm_mode_e m;
    m = CMM_OFF;
    if (mode[BIT_TOGGLE] && mode[BIT_PULSE])
      m = CMM_FREQ;
    else if (mode[BIT_PULSE])
      m = mode[BIT_WIDE] ? CMM_PWM_WIDE : CMM_PWM_NARROW;
    else if (mode[BIT_TOGGLE])
      m = CMM_TOGGLE;
    return m;
  endfunction

  // keeps the low 8 to 15 counter bits
  function automatic logic [15:0] cmm_pwm_mask(input logic [2:0] extra);
    logic [3:0] sh;
    sh = PWM_SPAN - {1'b0, extra};
    return MASK_ALL >> sh;
  endfunction
endpackage
`default_nettype wire

// File: src/cmm_match_if.sv
// carries compare value, counter and tick to the match detector, and its match pulses back
// assumes both ends share clk_in
`default_nettype none
interface cmm_match_if;
  logic [15:0] compare;
  logic [15:0] counter;
  logic tick;
  logic full_match;
  logic low_match;
  modport det (input compare, input counter, input tick, output full_match, output low_match);
  modport user (output compare, output counter, output tick, input full_match, input low_match);
endinterface
`default_nettype wire

// File: src/cmm_match.sv
// registered counter/compare match detector
// assumes counter is valid when tick is high
`default_nettype none
module cmm_match (
  input wire logic clk_in,     // system clock
  input wire logic rst_n_in,   // async reset, low
  input wire logic ce_in,      // clock enable
  cmm_match_if.det m           // match group
);
  logic full_r, full_nxt, low_r, low_nxt;

  always_comb
  begin
    full_nxt = m.tick && (m.counter == m.compare);
    low_nxt = m.tick && (m.counter[7:0] == m.compare[7:0]);
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      full_r <= 1'b0;
      low_r <= 1'b0;
    end
    else if (ce_in)
    begin
      full_r <= full_nxt;
      low_r <= low_nxt;
    end
  end

  assign m.full_match = full_r;
  assign m.low_match = low_r;

  property p_match_pulse;
    @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && m.tick && m.counter == m.compare) |=> m.full_match && m.low_match;
  endproperty
  a_match_pulse: assert property (p_match_pulse) else $error("match pulse missing");
endmodule // cmm_match
`default_nettype wire

// File: src/cmm_mode_ctrl.sv
// mode control for one capture/compare module with register port
// assumes counter and tick come from the shared counter, same clock
//
// Local design decisions: the register addresses and the strobed register port.
`default_nettype none
module cmm_mode_ctrl (
  input wire logic clk_in,            // system clock
  input wire logic rst_n_in,          // async reset, low
  input wire logic ce_in,             // clock enable, low freezes
  input wire logic [2:0] addr_in,     // register address
  input wire logic [7:0] wr_data_in,  // write data
  input wire logic wr_en_in,          // write strobe
  input wire logic rd_en_in,          // read strobe
  input wire logic [15:0] counter_in, // shared counter value
  input wire logic count_tick_in,     // counter value new
  output logic [7:0] rd_data_out,     // read data, cycle after strobe
  output logic pin_out,               // module output pin level
  output logic irq_out,               // flag interrupt request
  output logic wdt_reset_out          // watchdog expiry pulse
);
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [7:0] cmp_lo_r;
  logic [7:0] cmp_lo_nxt;
  logic [7:0] cmp_hi_r;
  logic [7:0] cmp_hi_nxt;
  logic [7:0] freq_tgt_r;
  logic [7:0] freq_tgt_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic flag_r;
  logic flag_nxt;
  logic pin_r;
  logic pin_nxt;
  logic irq_r;
  logic irq_nxt;
  logic wdt_rst_r;
  logic wdt_rst_nxt;
  logic wdt_lock;
  logic event_hit;
  logic [15:0] mask;
  cmm_pkg::cmm_mode_e mode_sel;

  cmm_match_if mif ();

  assign mode_sel = cmm_pkg::cmm_decode(mode_r);
  assign wdt_lock = ctrl_r[cmm_pkg::BIT_WDT_EN]
    && (cmm_pkg::MODULE_INDEX == cmm_pkg::WDT_MODULE);
  assign mask = cmm_pkg::cmm_pwm_mask(ctrl_r[cmm_pkg::EXTRA_MSB:cmm_pkg::EXTRA_LSB]);
  assign mif.compare = (mode_sel == cmm_pkg::CMM_FREQ) ? {cmp_hi_r, freq_tgt_r}
    : {cmp_hi_r, cmp_lo_r};
  assign mif.counter = counter_in;
  assign mif.tick = count_tick_in;

  cmm_match u_match (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .m        (mif.det)
  );

  // frequency mode runs on the low-byte match
  assign event_hit = (mode_sel == cmm_pkg::CMM_FREQ) ? mif.low_match : mif.full_match;

  always_comb
  begin
    mode_nxt = mode_r;
    cmp_lo_nxt = cmp_lo_r;
    cmp_hi_nxt = cmp_hi_r;
    freq_tgt_nxt = freq_tgt_r;
    ctrl_nxt = ctrl_r;
    flag_nxt = flag_r;
    pin_nxt = pin_r;
    rd_data_nxt = cmm_pkg::READ_ZERO;
    if (wr_en_in)
    begin
      case (addr_in)
        cmm_pkg::ADDR_MODE:
        begin
          if (!wdt_lock)
            mode_nxt = wr_data_in;
        end
        cmm_pkg::ADDR_CMP_LO:
        begin
          cmp_lo_nxt = wr_data_in;
          freq_tgt_nxt = wr_data_in;
        end
        cmm_pkg::ADDR_CMP_HI:
          cmp_hi_nxt = wr_data_in;
        cmm_pkg::ADDR_STATUS:
        begin
          if (wr_data_in[cmm_pkg::BIT_FLAG])
            flag_nxt = 1'b0;
        end
        cmm_pkg::ADDR_CTRL:
          ctrl_nxt = wr_data_in;
        default:
          ctrl_nxt = ctrl_r;
      endcase
    end
    if (mode_r[cmm_pkg::BIT_MATCH] && event_hit)
      flag_nxt = 1'b1;
    if (!wdt_lock)
    begin
      case (mode_sel)
        cmm_pkg::CMM_TOGGLE:
        begin
          if (mif.full_match)
            pin_nxt = !pin_r;
        end
        cmm_pkg::CMM_FREQ:
        begin
          if (mif.low_match)
          begin
            pin_nxt = !pin_r;
            freq_tgt_nxt = freq_tgt_r + cmp_hi_r;
          end
        end
        cmm_pkg::CMM_PWM_NARROW:
        begin
          if (count_tick_in)
            pin_nxt = (counter_in & mask) >= ({cmp_hi_r, cmp_lo_r} & mask);
        end
        cmm_pkg::CMM_PWM_WIDE:
        begin
          if (count_tick_in)
            pin_nxt = counter_in >= {cmp_hi_r, cmp_lo_r};
        end
        default:
          pin_nxt = pin_r;
      endcase
    end
    if (rd_en_in)
    begin
      case (addr_in)
        cmm_pkg::ADDR_MODE:
          rd_data_nxt = mode_r;
        cmm_pkg::ADDR_CMP_LO:
          rd_data_nxt = cmp_lo_r;
        cmm_pkg::ADDR_CMP_HI:
          rd_data_nxt = cmp_hi_r;
        cmm_pkg::ADDR_STATUS:
        begin
          rd_data_nxt[cmm_pkg::BIT_FLAG] = flag_r;
          rd_data_nxt[cmm_pkg::BIT_PIN] = pin_r;
          rd_data_nxt[cmm_pkg::BIT_IRQ] = irq_r;
        end
        cmm_pkg::ADDR_CTRL:
          rd_data_nxt = ctrl_r;
        default:
          rd_data_nxt = cmm_pkg::READ_ZERO;
      endcase
    end
    wdt_rst_nxt = wdt_lock && mif.full_match;
    irq_nxt = flag_nxt && mode_nxt[cmm_pkg::BIT_IRQ_EN];
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode_r <= cmm_pkg::MODE_RESET;
      cmp_lo_r <= cmm_pkg::CMP_RESET;
      cmp_hi_r <= cmm_pkg::CMP_RESET;
      freq_tgt_r <= cmm_pkg::CMP_RESET;
      ctrl_r <= cmm_pkg::CTRL_RESET;
      rd_data_r <= cmm_pkg::READ_ZERO;
      flag_r <= 1'b0;
      pin_r <= 1'b0;
      irq_r <= 1'b0;
      wdt_rst_r <= 1'b0;
    end
    else if (ce_in)
    begin
      mode_r <= mode_nxt;
      cmp_lo_r <= cmp_lo_nxt;
      cmp_hi_r <= cmp_hi_nxt;
      freq_tgt_r <= freq_tgt_nxt;
      ctrl_r <= ctrl_nxt;
      rd_data_r <= rd_data_nxt;
      flag_r <= flag_nxt;
      pin_r <= pin_nxt;
      irq_r <= irq_nxt;
      wdt_rst_r <= wdt_rst_nxt;
    end
  end

  assign rd_data_out = rd_data_r;
  assign pin_out = pin_r;
  assign irq_out = irq_r;
  assign wdt_reset_out = wdt_rst_r;

  property p_flag_set;
    @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && mode_r[cmm_pkg::BIT_MATCH] && event_hit) |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on match");

  property p_toggle;
    @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && !wdt_lock && mode_sel == cmm_pkg::CMM_TOGGLE && mif.full_match)
        |=> (pin_r != $past(pin_r));
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle");

  property p_freq;
    @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && !wdt_lock && mode_r[cmm_pkg::BIT_TOGGLE] && mode_r[cmm_pkg::BIT_PULSE]
        && mif.low_match) |=> (pin_r != $past(pin_r));
  endproperty
  a_freq: assert property (p_freq) else $error("frequency output did not toggle");

  property p_pwm_wide;
    @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && !wdt_lock && mode_sel == cmm_pkg::CMM_PWM_WIDE && count_tick_in)
        |=> (pin_r == ($past(counter_in) >= {$past(cmp_hi_r), $past(cmp_lo_r)}));
  endproperty
  a_pwm_wide: assert property (p_pwm_wide) else $error("wide modulator level wrong");

  property p_pwm_narrow;
    @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && !wdt_lock && mode_sel == cmm_pkg::CMM_PWM_NARROW && count_tick_in
        && ((counter_in & mask) < ({cmp_hi_r, cmp_lo_r} & mask))) |=> !pin_r;
  endproperty
  a_pwm_narrow: assert property (p_pwm_narrow) else $error("narrow modulator level wrong");

  property p_irq;
    @(posedge clk_in) disable iff (!rst_n_in)
      (flag_r && mode_r[cmm_pkg::BIT_IRQ_EN]) |-> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request missing");

  property p_lock;
    @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && wdt_lock && wr_en_in && addr_in == cmm_pkg::ADDR_MODE) |=> $stable(mode_r);
  endproperty
  a_lock: assert property (p_lock) else $error("locked mode register changed");

  property p_wdt;
    @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && wdt_lock && mif.full_match) |=> wdt_reset_out
        ##1 (!$past(ce_in) || !wdt_reset_out || $past(mif.full_match));
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog pulse wrong");

  property p_no_irq;
    @(posedge clk_in) disable iff (!rst_n_in)
      !mode_r[cmm_pkg::BIT_IRQ_EN] |-> !irq_out;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("masked flag raised request");

  property p_read_status;
    @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && rd_en_in && addr_in == cmm_pkg::ADDR_STATUS)
        |=> (rd_data_out[cmm_pkg::BIT_FLAG] == $past(flag_r));
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read wrong");

  c_toggle: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    mode_sel == cmm_pkg::CMM_TOGGLE && mif.full_match);
  c_freq: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    mode_sel == cmm_pkg::CMM_FREQ && mif.low_match);
  c_irq: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(irq_out));
  c_lock: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    wdt_lock && wr_en_in && addr_in == cmm_pkg::ADDR_MODE);
endmodule // cmm_mode_ctrl
`default_nettype wire

// File: test/counter_module_mode_control_tb.sv
// self-checking bench for the capture/compare module mode control
// assumes the design files under src/ are compiled first
`default_nettype none
module counter_module_mode_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in;
  logic rst_n_in;
  logic ce_in;
  logic [2:0] addr_in;
  logic [7:0] wr_data_in;
  logic wr_en_in;
  logic rd_en_in;
  logic [15:0] counter_in;
  logic count_tick_in;
  logic [7:0] rd_data_out;
  logic pin_out;
  logic irq_out;
  logic wdt_reset_out;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;

  cmm_mode_ctrl u_cmm_mode_ctrl (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .addr_in(addr_in),
    .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in),
    .counter_in(counter_in),
    .count_tick_in(count_tick_in),
    .rd_data_out(rd_data_out),
    .pin_out(pin_out),
    .irq_out(irq_out),
    .wdt_reset_out(wdt_reset_out)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      bad_count++;
      stop_test();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1;
    check(name, rd_data_out, exp);
  endtask

  // tick taken at the second edge of the task; then waits n more edges before returning
  task automatic tick(input logic [15:0] v, input int n);
    @(posedge clk_in);
    count_tick_in <= 1'b1;
    counter_in <= v;
    @(posedge clk_in);
    count_tick_in <= 1'b0;
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic test_reset();
    rd_chk("mode", cmm_pkg::ADDR_MODE, 8'h00);
    rd_chk("cmp_lo", cmm_pkg::ADDR_CMP_LO, 8'h00);
    rd_chk("cmp_hi", cmm_pkg::ADDR_CMP_HI, 8'h00);
    rd_chk("status", cmm_pkg::ADDR_STATUS, 8'h00);
    rd_chk("ctrl", cmm_pkg::ADDR_CTRL, 8'h00);
    wr(3'h5, 8'hA5);
    rd_chk("unmapped", 3'h5, 8'h00);
    rd_chk("mode after unmapped", cmm_pkg::ADDR_MODE, 8'h00);
    $display("test reset done");
  endtask

  task automatic test_match();
    wr(cmm_pkg::ADDR_MODE, 8'h0D);
    wr(cmm_pkg::ADDR_CMP_LO, 8'h34);
    wr(cmm_pkg::ADDR_CMP_HI, 8'h12);
    tick(16'h1235, 2);
    rd_chk("status no match", cmm_pkg::ADDR_STATUS, 8'h00);
    tick(16'h1234, 2);
    check("pin toggled", {7'h00, pin_out}, 8'h01);
    check("irq", {7'h00, irq_out}, 8'h01);
    rd_chk("status match", cmm_pkg::ADDR_STATUS, 8'h07);
    wr(cmm_pkg::ADDR_STATUS, 8'h01);
    #1;
    check("irq cleared", {7'h00, irq_out}, 8'h00);
    rd_chk("status cleared", cmm_pkg::ADDR_STATUS, 8'h02);
    tick(16'h1234, 2);
    check("pin toggled back", {7'h00, pin_out}, 8'h00);
    wr(cmm_pkg::ADDR_STATUS, 8'h01);
    $display("test match done");
  endtask

  task automatic test_irq_masked();
    wr(cmm_pkg::ADDR_MODE, 8'h08);
    tick(16'h1234, 2);
    check("irq masked", {7'h00, irq_out}, 8'h00);
    check("pin held", {7'h00, pin_out}, 8'h00);
    rd_chk("flag set masked", cmm_pkg::ADDR_STATUS, 8'h01);
    wr(cmm_pkg::ADDR_MODE, 8'h09);
    #1;
    check("irq unmasked", {7'h00, irq_out}, 8'h01);
    wr(cmm_pkg::ADDR_STATUS, 8'h01);
    $display("test irq mask done");
  endtask

  task automatic test_watchdog();
    wr(cmm_pkg::ADDR_MODE, 8'h08);
    wr(cmm_pkg::ADDR_CTRL, 8'h01);
    wr(cmm_pkg::ADDR_MODE, 8'h0C);
    rd_chk("mode locked", cmm_pkg::ADDR_MODE, 8'h08);
    tick(16'h1234, 1);
    check("wdt pulse", {7'h00, wdt_reset_out}, 8'h01);
    @(posedge clk_in);
    #1;
    check("wdt pulse end", {7'h00, wdt_reset_out}, 8'h00);
    check("pin held locked", {7'h00, pin_out}, 8'h00);
    wr(cmm_pkg::ADDR_CTRL, 8'h00);
    wr(cmm_pkg::ADDR_MODE, 8'h0C);
    rd_chk("mode unlocked", cmm_pkg::ADDR_MODE, 8'h0C);
    wr(cmm_pkg::ADDR_STATUS, 8'h01);
    $display("test watchdog done");
  endtask

  task automatic test_pwm();
    wr(cmm_pkg::ADDR_MODE, 8'h02);
    wr(cmm_pkg::ADDR_CMP_LO, 8'h80);
    wr(cmm_pkg::ADDR_CMP_HI, 8'h00);
    tick(16'h0090, 0);
    check("narrow high", {7'h00, pin_out}, 8'h01);
    tick(16'h0110, 0);
    check("narrow low", {7'h00, pin_out}, 8'h00);
    wr(cmm_pkg::ADDR_CTRL, 8'h02);
    tick(16'h0110, 0);
    check("9-bit high", {7'h00, pin_out}, 8'h01);
    tick(16'h0270, 0);
    check("9-bit low", {7'h00, pin_out}, 8'h00);
    wr(cmm_pkg::ADDR_CTRL, 8'h00);
    wr(cmm_pkg::ADDR_MODE, 8'h82);
    tick(16'h0110, 0);
    check("wide high", {7'h00, pin_out}, 8'h01);
    tick(16'h007F, 0);
    check("wide low", {7'h00, pin_out}, 8'h00);
    $display("test pwm done");
  endtask

  task automatic test_freq();
    wr(cmm_pkg::ADDR_MODE, 8'h06);
    wr(cmm_pkg::ADDR_CMP_HI, 8'h20);
    wr(cmm_pkg::ADDR_CMP_LO, 8'h40);
    tick(16'h0040, 2);
    check("freq toggle 1", {7'h00, pin_out}, 8'h01);
    tick(16'h0050, 2);
    check("freq hold", {7'h00, pin_out}, 8'h01);
    tick(16'h0060, 2);
    check("freq toggle 2", {7'h00, pin_out}, 8'h00);
    $display("test freq done");
  endtask

  // match while clock enable low must leave pin and flag alone
  task automatic test_freeze();
    wr(cmm_pkg::ADDR_MODE, 8'h0C);
    wr(cmm_pkg::ADDR_CMP_LO, 8'h34);
    wr(cmm_pkg::ADDR_CMP_HI, 8'h12);
    @(posedge clk_in);
    ce_in <= 1'b0;
    tick(16'h1234, 2);
    check("frozen pin", {7'h00, pin_out}, 8'h00);
    @(posedge clk_in);
    ce_in <= 1'b1;
    rd_chk("frozen flag", cmm_pkg::ADDR_STATUS, 8'h00);
    $display("test freeze done");
  endtask

  initial
  begin
    rst_n_in = 1'b0;
    ce_in = 1'b1;
    addr_in = 3'h0;
    wr_data_in = 8'h00;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    counter_in = 16'h0000;
    count_tick_in = 1'b0;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    test_reset();
    test_match();
    test_irq_masked();
    test_watchdog();
    test_pwm();
    test_freq();
    test_freeze();
    stop_test();
  end
endmodule // counter_module_mode_control_tb
`default_nettype wire
